/* File: src/pcs_word_aligner.sv */
// Lane core: APB registers, 8b10b transmit encoder, comma word aligner
// with byte-pair shift, receive decoder lanes and one interrupt line.
// Assumes SERDES parallel words and user data are synchronous to pclk.
`timescale 1ns/100ps

// Operation
// - Serdes word width 10, 20, 40 or 80
// - Lane mode selects transmit, receive or both
// - User width is serdes width/10 times 8
// - One flag bit per byte lane, except invalid_k, one bit for the whole word
// - Byte-pair shift ignored at 10-bit width
// - Alignment granularity follows shift and width
// - Shift puts first data bytes at top
// - Without shift, upper-slot comma leaves byte offset
// - Count enable picks programmable or fixed run
// - Lock needs configured run, 1 to 4095
// - Comma select picks K28.5, K28.1, any, K28.7
// - Transmit and receive both run on pclk
// - Four consecutive errors drop lock, restart search
// - Fixed mode locks after four consecutive commas
// - code_err_n flags error-free lanes, whether aligned or not
module pcs_word_aligner #(
  parameter int  SERDES_WORD_WIDTH               = 20,
  parameter int  LANE_MODE                       = pcs_pkg::LANE_BOTH,
  parameter int  SHIFT_EN                        = 0,
  parameter int  PROGRAMMABLE_COMMA_COUNT_ENABLE = 0,
  parameter int  COMMA_RUN_LENGTH                = 4,
  parameter int  COMMA_SEL                       = pcs_pkg::COMMA_K285,
  localparam int N               = SERDES_WORD_WIDTH / pcs_pkg::SYM_W,
  localparam int USER_DATA_WIDTH = N * pcs_pkg::BYTE_W
) (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic [pcs_pkg::APB_AW-1:0]   paddr,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  output logic                              irq,
  input  wire logic [USER_DATA_WIDTH-1:0]   tx_data,
  input  wire logic [N-1:0]                 tx_k_char,
  input  wire logic [N-1:0]                 force_disp,
  input  wire logic [N-1:0]                 disp_sel,
  output logic      [SERDES_WORD_WIDTH-1:0] serdes_tx_word,
  output logic                              invalid_k,
  input  wire logic [SERDES_WORD_WIDTH-1:0] serdes_rx_word,
  output logic      [USER_DATA_WIDTH-1:0]   rx_data,
  output logic      [N-1:0]                 rx_k_char,
  output logic      [N-1:0]                 rx_code_err,
  output logic      [N-1:0]                 rx_disp_err,
  output logic      [N-1:0]                 code_err_n,
  output logic                              aligned,
  output logic                              comma_search_request
);
  localparam int W    = SERDES_WORD_WIDTH;
  localparam int SW   = pcs_pkg::SYM_W;
  localparam int CW   = pcs_pkg::CNT_W;
  localparam int SH_W = $clog2(N) + 1;
  localparam bit TX_ON    = (LANE_MODE != pcs_pkg::LANE_RX);
  localparam bit RX_ON    = (LANE_MODE != pcs_pkg::LANE_TX);
  localparam bit SHIFT_ON = (SHIFT_EN != 0) && (N > 1);
  localparam logic [CW-1:0] NEED = (CW)'((PROGRAMMABLE_COMMA_COUNT_ENABLE != 0) ?
                                     COMMA_RUN_LENGTH : pcs_pkg::FIXED_RUN);

  typedef enum logic {PCS_SEARCH, PCS_LOCKED} pcs_align_t;

  function automatic logic is_comma(input logic [SW-1:0] s);
    logic k1;
    logic k5;
    logic k7;
    k1 = (s == pcs_pkg::K281_RDN) || (s == ~pcs_pkg::K281_RDN);
    k5 = (s == pcs_pkg::K285_RDN) || (s == ~pcs_pkg::K285_RDN);
    k7 = (s == pcs_pkg::K287_RDN) || (s == ~pcs_pkg::K287_RDN);
    if (COMMA_SEL == pcs_pkg::COMMA_K281) return k1;
    if (COMMA_SEL == pcs_pkg::COMMA_ANY) return k1 | k5 | k7;
    if (COMMA_SEL == pcs_pkg::COMMA_K287) return k7;
    return k5;
  endfunction : is_comma

  function automatic logic has_comma(input logic [W-1:0] w);
    logic r;
    r = 1'b0;
    for (int i = 0; i < N; i++) r |= is_comma(w[i*SW +: SW]);
    return r;
  endfunction : has_comma

  // Slots are walked upper first, the order they left the sender
  function automatic logic [CW-1:0] run_len(input logic [CW-1:0] c,
                                            input logic [W-1:0]  w);
    logic [CW-1:0] r;
    r = c;
    for (int i = N - 1; i >= 0; i--) begin
      if (!is_comma(w[i*SW +: SW])) r = '0;
      else if (r != '1) r = r + 1'b1;
    end
    return r;
  endfunction : run_len

  // Number of data slots that follow the last comma in a word
  function automatic logic [SH_W-1:0] tail_slots(input logic [W-1:0] w);
    logic [SH_W-1:0] t;
    t = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (is_comma(w[i*SW +: SW])) t = SH_W'(i);
    end
    return t;
  endfunction : tail_slots

  function automatic logic [SW:0] encode(input logic [7:0] b,
                                         input logic       k,
                                         input logic       rd);
    logic [4:0] x;
    logic [2:0] y;
    logic       k28;
    logic       a7;
    logic       rdm;
    logic       unb4;
    logic [5:0] t6;
    logic [3:0] t4;
    logic [3:0] tp;
    logic [3:0] c4;
    x   = b[4:0];
    y   = b[7:5];
    k28 = k && (x == pcs_pkg::K28_X);
    t6  = k28 ? pcs_pkg::K28_6B : pcs_pkg::ENC6[x];
    rdm = ($countones(t6) != pcs_pkg::HALF6) ? ~rd : rd;
    if (rd && ($countones(t6) != pcs_pkg::HALF6 || (!k28 && x == pcs_pkg::D7_X))) t6 = ~t6;
    a7  = (y == pcs_pkg::Y7) && (k || (rdm ? pcs_pkg::A7_RDP_X[x] : pcs_pkg::A7_RDN_X[x]));
    t4  = a7 ? pcs_pkg::ALT7_4B : pcs_pkg::ENC4[y];
    unb4 = ($countones(t4) != pcs_pkg::HALF4);
    tp  = (unb4 || y == pcs_pkg::Y3) ? ~t4 : t4;
    // K28 flips its neutral 3b4b codes as well
    c4  = rdm ? tp : (k28 ? ~tp : t4);
    return {unb4 ? ~rdm : rdm, t6, c4};
  endfunction : encode

  function automatic logic k_ok(input logic [7:0] b);
    return (b[4:0] == pcs_pkg::K28_X) || (b[7:5] == pcs_pkg::Y7 && pcs_pkg::K7_X[b[4:0]]);
  endfunction : k_ok

  // APB slave, one wait state so that read data comes from a flop
  logic [31:0]              ctrl_q;
  logic [pcs_pkg::EV_W-1:0] stat_q;
  logic [pcs_pkg::EV_W-1:0] mask_q;
  logic [pcs_pkg::EV_W-1:0] ev;
  logic [pcs_pkg::ERRC_W-1:0] errc_q;
  logic [31:0]              rd_mux;
  logic                     hit;
  logic                     acc;
  logic                     wr_fire;
  logic                     resync;

  assign acc     = psel & penable;
  assign wr_fire = acc & pready & pwrite;
  assign resync  = wr_fire && paddr == pcs_pkg::REG_CTRL && pwdata[pcs_pkg::CTRL_RESYNC];

  // Lane state
  pcs_align_t                st_q;
  pcs_align_t                st_d;
  logic [pcs_pkg::OFF_W-1:0] cand_q;
  logic [pcs_pkg::OFF_W-1:0] cand_d;
  logic [CW-1:0]             cnt_q;
  logic [CW-1:0]             cnt_d;
  logic [pcs_pkg::ERR_W-1:0] err_q;
  logic [pcs_pkg::ERR_W-1:0] err_d;
  logic [SH_W-1:0]           sh_q;
  logic [W-1:0]              raw1_q;
  logic [W-1:0]              raw2_q;
  logic [W-1:0]              aligned_raw_word;
  logic [W-1:0]              prev_q;
  logic [W-1:0]              cur_w;
  logic [W-1:0]              dec_in;
  logic [USER_DATA_WIDTH-1:0] decoded_pair_word;
  logic [N-1:0]              dec_k;
  logic [N-1:0]              dec_cerr;
  logic [N-1:0]              dec_rderr;
  logic [N:0]                rdc;
  logic                      rx_rd_q;
  logic                      word_err;
  logic                      tx_rd_q;
  logic [W-1:0]              tx_word_d;
  logic                      bad_k;
  logic                      rdt;
  logic [SW:0]               enc;
  logic [7:0]                tb;
  logic                      tk;

  always_comb begin
    hit    = 1'b1;
    rd_mux = '0;
    unique case (paddr)
      pcs_pkg::REG_CTRL:     rd_mux = ctrl_q;
      pcs_pkg::REG_STATUS: begin
        rd_mux[pcs_pkg::ST_ALIGNED] = aligned;
        rd_mux[pcs_pkg::ST_SEARCH]  = comma_search_request;
        rd_mux[pcs_pkg::ST_OFF_LSB +: pcs_pkg::OFF_W] = cand_q;
        rd_mux[pcs_pkg::ST_SH_LSB +: SH_W] = sh_q;
      end
      pcs_pkg::REG_IRQ_STAT: rd_mux[pcs_pkg::EV_W-1:0] = stat_q;
      pcs_pkg::REG_IRQ_MASK: rd_mux[pcs_pkg::EV_W-1:0] = mask_q;
      pcs_pkg::REG_ERRCNT:   rd_mux[pcs_pkg::ERRC_W-1:0] = errc_q;
      pcs_pkg::REG_CONFIG: begin
        rd_mux[pcs_pkg::CF_MODE-1:0] = 8'(SERDES_WORD_WIDTH);
        rd_mux[pcs_pkg::CF_MODE +: 2] = 2'(LANE_MODE);
        rd_mux[pcs_pkg::CF_SHIFT]     = SHIFT_ON;
        rd_mux[pcs_pkg::CF_PROG]      = (PROGRAMMABLE_COMMA_COUNT_ENABLE != 0);
        rd_mux[pcs_pkg::CF_SEL +: 2]  = 2'(COMMA_SEL);
        rd_mux[pcs_pkg::CF_NEED +: CW] = NEED;
      end
      default:               hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc & ~pready;
      pslverr <= acc & ~pready & ~hit;
      if (acc & ~pready & ~pwrite) prdata <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 32'h0000_0002;
      mask_q <= '0;
    end else if (wr_fire) begin
      // Resync bit is a strobe and never stored
      if (paddr == pcs_pkg::REG_CTRL) ctrl_q[pcs_pkg::CTRL_TX_EN] <= pwdata[pcs_pkg::CTRL_TX_EN];
      if (paddr == pcs_pkg::REG_IRQ_MASK) mask_q <= pwdata[pcs_pkg::EV_W-1:0];
    end
  end

  // Sticky status: a new event beats a same-cycle write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= '0;
      irq    <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~((wr_fire && paddr == pcs_pkg::REG_IRQ_STAT) ?
                           pwdata[pcs_pkg::EV_W-1:0] : '0)) | ev;
      irq    <= |(stat_q & mask_q);
    end
  end

  // Transmit: both lanes share pclk, so no crossing is needed
  always_comb begin
    rdt       = tx_rd_q;
    tx_word_d = '0;
    bad_k     = 1'b0;
    enc       = '0;
    tb        = '0;
    tk        = 1'b0;
    for (int i = N - 1; i >= 0; i--) begin
      tb = ctrl_q[pcs_pkg::CTRL_TX_EN] ? tx_data[i*8 +: 8] : pcs_pkg::IDLE_BYTE;
      tk = ctrl_q[pcs_pkg::CTRL_TX_EN] ? tx_k_char[i] : 1'b1;
      if (force_disp[i]) rdt = disp_sel[i];
      enc = encode(tb, tk, rdt);
      rdt = enc[SW];
      tx_word_d[i*SW +: SW] = enc[SW-1:0];
      bad_k |= tk & ~k_ok(tb);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serdes_tx_word <= '0;
      invalid_k      <= 1'b0;
      tx_rd_q        <= 1'b0;
    end else if (TX_ON) begin
      serdes_tx_word <= tx_word_d;
      invalid_k      <= bad_k;
      tx_rd_q        <= rdt;
    end
  end

  // Receive: search any bit offset, then count a run at one offset
  always_comb begin
    st_d   = st_q;
    cand_d = cand_q;
    cnt_d  = cnt_q;
    err_d  = err_q;
    cur_w  = W'({raw2_q, raw1_q} >> cand_q);
    unique case (st_q)
      PCS_SEARCH: begin
        if (has_comma(cur_w)) begin
          cnt_d = run_len(cnt_q, cur_w);
        end else begin
          cnt_d = '0;
          for (int o = SW - 1; o >= 0; o--) begin
            if (has_comma(W'({raw2_q, raw1_q} >> o))) begin
              cand_d = pcs_pkg::OFF_W'(o);
              cnt_d  = run_len('0, W'({raw2_q, raw1_q} >> o));
            end
          end
        end
        if (cnt_d >= NEED) begin
          st_d  = PCS_LOCKED;
          err_d = '0;
        end
      end
      PCS_LOCKED: begin
        err_d = word_err ? err_q + 1'b1 : '0;
        if (err_d == pcs_pkg::ERR_W'(pcs_pkg::ERR_LIMIT) || resync) begin
          st_d  = PCS_SEARCH;
          cnt_d = '0;
        end
      end
    endcase
  end

  assign ev[pcs_pkg::EV_LOCK] = st_q == PCS_SEARCH && st_d == PCS_LOCKED;
  assign ev[pcs_pkg::EV_LOSS] = st_q == PCS_LOCKED && st_d == PCS_SEARCH;
  assign ev[pcs_pkg::EV_CERR] = st_q == PCS_LOCKED && word_err;
  assign ev[pcs_pkg::EV_BADK] = TX_ON && bad_k;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q   <= PCS_SEARCH;
      cand_q <= '0;
      cnt_q  <= '0;
      err_q  <= '0;
      raw1_q <= '0;
      raw2_q <= '0;
    end else if (RX_ON) begin
      st_q   <= st_d;
      cand_q <= cand_d;
      cnt_q  <= cnt_d;
      err_q  <= err_d;
      raw1_q <= serdes_rx_word;
      raw2_q <= raw1_q;
    end
  end

  // Byte-pair shift: hold the slots after the last comma and pair them
  // with the head of the next word; the held slots leave one word later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aligned_raw_word <= '0;
      prev_q           <= '0;
      sh_q             <= '0;
    end else begin
      aligned_raw_word <= cur_w;
      prev_q           <= aligned_raw_word;
      if (SHIFT_ON && has_comma(aligned_raw_word)) begin
        sh_q <= tail_slots(aligned_raw_word);
      end else if (!SHIFT_ON) begin
        sh_q <= '0;
      end
    end
  end

  assign dec_in = W'({prev_q, aligned_raw_word} >> (sh_q * SW));
  assign rdc[N] = rx_rd_q;

  generate
    if (RX_ON) begin : g_rx
      for (genvar i = 0; i < N; i++) begin : g_lane
        pcs_sym_dec u_dec (
          .sym      (dec_in[i*SW +: SW]),
          .rd_in    (rdc[i+1]),
          .dbyte    (decoded_pair_word[i*8 +: 8]),
          .is_k     (dec_k[i]),
          .code_err (dec_cerr[i]),
          .disp_err (dec_rderr[i]),
          .rd_out   (rdc[i])
        );
      end
    end else begin : g_no_rx
      assign decoded_pair_word = '0;
      assign dec_k     = '0;
      assign dec_cerr  = '0;
      assign dec_rderr = '0;
      assign rdc[N-1:0] = '0;
    end
  endgenerate

  assign word_err = |(dec_cerr | dec_rderr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_rd_q              <= 1'b0;
      rx_data              <= '0;
      rx_k_char            <= '0;
      rx_code_err          <= '0;
      rx_disp_err          <= '0;
      code_err_n           <= '1;
      aligned              <= 1'b0;
      comma_search_request <= 1'b1;
      errc_q               <= '0;
    end else begin
      rx_rd_q              <= rdc[0];
      rx_data              <= decoded_pair_word;
      rx_k_char            <= dec_k;
      rx_code_err          <= dec_cerr;
      rx_disp_err          <= dec_rderr;
      code_err_n           <= ~(dec_cerr | dec_rderr);
      aligned              <= st_d == PCS_LOCKED;
      comma_search_request <= st_d == PCS_SEARCH;
      if (wr_fire && paddr == pcs_pkg::REG_ERRCNT) errc_q <= '0;
      else if (ev[pcs_pkg::EV_CERR] && errc_q != '1) errc_q <= errc_q + 1'b1;
    end
  end
endmodule : pcs_word_aligner

/* File: src/pcs_pkg.sv */
// Shared constants for the 8b10b lane: register map, code tables, commas.
// Symbols are held as {abcdei, fghj}; bit 9 is the first bit on the line.
package pcs_pkg;
  localparam int SYM_W  = 10;
  localparam int BYTE_W = 8;
  localparam int CNT_W  = 12;
  localparam int ERR_W  = 3;
  localparam int OFF_W  = 4;
  localparam int EV_W   = 4;
  localparam int ERRC_W = 16;
  localparam int HALF6  = 3;
  localparam int HALF4  = 2;

  localparam int LANE_TX   = 0;
  localparam int LANE_RX   = 1;
  localparam int LANE_BOTH = 2;

  localparam int COMMA_K285 = 0;
  localparam int COMMA_K281 = 1;
  localparam int COMMA_ANY  = 2;
  localparam int COMMA_K287 = 3;

  localparam int FIXED_RUN = 4;
  localparam int ERR_LIMIT = 4;

  localparam logic [9:0]  K285_RDN  = 10'h0FA;
  localparam logic [9:0]  K281_RDN  = 10'h0F9;
  localparam logic [9:0]  K287_RDN  = 10'h0F8;
  localparam logic [5:0]  K28_6B    = 6'h0F;
  localparam logic [3:0]  ALT7_4B   = 4'h7;
  localparam logic [4:0]  K28_X     = 5'h1C;
  localparam logic [4:0]  D7_X      = 5'h07;
  localparam logic [2:0]  Y3        = 3'h3;
  localparam logic [2:0]  Y7        = 3'h7;
  localparam logic [7:0]  IDLE_BYTE = 8'hBC;
  localparam logic [31:0] A7_RDN_X  = 32'h0016_0000;
  localparam logic [31:0] A7_RDP_X  = 32'h0000_6800;
  localparam logic [31:0] K7_X      = 32'h6880_0000;

  // Negative-disparity column of the 5b6b and 3b4b sub-block codes
  localparam logic [5:0] ENC6 [32] = '{
    6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
    6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
  localparam logic [3:0] ENC4 [8] = '{
    4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

  localparam int APB_AW = 12;
  localparam logic [APB_AW-1:0] REG_CTRL     = 12'h000;
  localparam logic [APB_AW-1:0] REG_STATUS   = 12'h004;
  localparam logic [APB_AW-1:0] REG_IRQ_STAT = 12'h008;
  localparam logic [APB_AW-1:0] REG_IRQ_MASK = 12'h00C;
  localparam logic [APB_AW-1:0] REG_ERRCNT   = 12'h010;
  localparam logic [APB_AW-1:0] REG_CONFIG   = 12'h014;

  localparam int CTRL_RESYNC = 0;
  localparam int CTRL_TX_EN  = 1;
  localparam int ST_ALIGNED  = 0;
  localparam int ST_SEARCH   = 1;
  localparam int ST_OFF_LSB  = 4;
  localparam int ST_SH_LSB   = 8;
  localparam int EV_LOCK     = 0;
  localparam int EV_LOSS     = 1;
  localparam int EV_CERR     = 2;
  localparam int EV_BADK     = 3;
  localparam int CF_MODE     = 8;
  localparam int CF_SHIFT    = 10;
  localparam int CF_PROG     = 11;
  localparam int CF_SEL      = 12;
  localparam int CF_NEED     = 16;
endpackage : pcs_pkg

/* File: src/pcs_sym_dec.sv */
// One 10-bit symbol decoder with code and running-disparity checks.
// Purely combinational; the caller chains rd_out into the next symbol.
`timescale 1ns/100ps

module pcs_sym_dec (
  input  wire logic [pcs_pkg::SYM_W-1:0] sym,
  input  wire logic                      rd_in,
  output logic      [7:0]                dbyte,
  output logic                           is_k,
  output logic                           code_err,
  output logic                           disp_err,
  output logic                           rd_out
);
  logic [5:0] s6;
  logic [3:0] s4;
  logic [4:0] x;
  logic [2:0] y;
  logic       hit6;
  logic       hit4;
  logic       k28;
  logic       a7;
  logic       rdm;
  int         n6;
  int         n4;

  always_comb begin
    s6   = sym[9:4];
    s4   = sym[3:0];
    x    = '0;
    y    = '0;
    hit6 = 1'b0;
    hit4 = 1'b0;
    a7   = 1'b0;
    k28  = (s6 == pcs_pkg::K28_6B) || (s6 == ~pcs_pkg::K28_6B);
    for (int i = 0; i < 32; i++) begin
      if (s6 == pcs_pkg::ENC6[i] || (s6 == ~pcs_pkg::ENC6[i] &&
          ($countones(pcs_pkg::ENC6[i]) != pcs_pkg::HALF6 || i == pcs_pkg::D7_X))) begin
        hit6 = 1'b1;
        x    = 5'(i);
      end
    end
    if (k28) x = pcs_pkg::K28_X;
    for (int i = 0; i < 8; i++) begin
      if (s4 == pcs_pkg::ENC4[i] || (s4 == ~pcs_pkg::ENC4[i] && (k28 || i == pcs_pkg::Y3 ||
          $countones(pcs_pkg::ENC4[i]) != pcs_pkg::HALF4))) begin
        hit4 = 1'b1;
        y    = 3'(i);
      end
    end
    if (s4 == pcs_pkg::ALT7_4B || s4 == ~pcs_pkg::ALT7_4B) begin
      hit4 = 1'b1;
      y    = pcs_pkg::Y7;
      a7   = 1'b1;
    end
    n6     = $countones(s6);
    n4     = $countones(s4);
    rdm    = (n6 > pcs_pkg::HALF6) ? 1'b1 : (n6 < pcs_pkg::HALF6) ? 1'b0 : rd_in;
    rd_out = (n4 > pcs_pkg::HALF4) ? 1'b1 : (n4 < pcs_pkg::HALF4) ? 1'b0 : rdm;
    dbyte  = {y, x};
    is_k   = k28 || (a7 && pcs_pkg::K7_X[x]);
    code_err = !(hit6 || k28) || !hit4 || (a7 && !k28 && !pcs_pkg::K7_X[x] &&
               !(rdm ? pcs_pkg::A7_RDP_X[x] : pcs_pkg::A7_RDN_X[x]));
    // Neutral D.7 and x.3 codes still carry a disparity direction
    disp_err = (n6 > pcs_pkg::HALF6 && rd_in) || (n6 < pcs_pkg::HALF6 && !rd_in) ||
               (s6 == pcs_pkg::ENC6[pcs_pkg::D7_X] && rd_in) ||
               (s6 == ~pcs_pkg::ENC6[pcs_pkg::D7_X] && !rd_in) ||
               (n4 > pcs_pkg::HALF4 && rdm) || (n4 < pcs_pkg::HALF4 && !rdm) ||
               (!k28 && s4 == pcs_pkg::ENC4[pcs_pkg::Y3] && rdm) ||
               (!k28 && s4 == ~pcs_pkg::ENC4[pcs_pkg::Y3] && !rdm);
  end
endmodule : pcs_sym_dec

/* File: tb/pcs_word_aligner_props.sv */
// Port assertions for the lane core.
// Assumes one clock, bound into every pcs_word_aligner.
`timescale 1ns/100ps
module pcs_word_aligner_props #(
  parameter int  SERDES_WORD_WIDTH = 20,
  localparam int N                 = SERDES_WORD_WIDTH / 10
) (
  input wire logic                         pclk,
  input wire logic                         presetn,
  input wire logic                         aligned,
  input wire logic                         comma_search_request,
  input wire logic [N-1:0]                 rx_code_err,
  input wire logic [N-1:0]                 rx_disp_err,
  input wire logic [N-1:0]                 code_err_n,
  input wire logic [N*8-1:0]               tx_data,
  input wire logic [N-1:0]                 tx_k_char,
  input wire logic [N-1:0]                 force_disp,
  input wire logic [SERDES_WORD_WIDTH-1:0] serdes_tx_word,
  input wire logic                         invalid_k
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_srch; aligned |-> !comma_search_request; endproperty
  a_srch: assert property (p_srch) else $error("search while aligned");
  property p_lost; !aligned |-> comma_search_request; endproperty
  a_lost: assert property (p_lost) else $error("no search while unaligned");
  property p_rise; $rose(aligned) |-> $past(comma_search_request); endproperty
  a_rise: assert property (p_rise) else $error("lock without search");
  property p_cerr; (&code_err_n) |-> !(|rx_code_err) && !(|rx_disp_err); endproperty
  a_cerr: assert property (p_cerr) else $error("error hidden from flag");
  property p_lane; (rx_code_err & code_err_n) == '0; endproperty
  a_lane: assert property (p_lane) else $error("lane flag mismatch");
  property p_k285;
    $past(presetn) && $past(&tx_k_char) && $past(tx_data) == {N{8'hBC}} && !$past(|force_disp)
      |-> serdes_tx_word[9:0] inside {10'h0FA, 10'h305}
      && serdes_tx_word[SERDES_WORD_WIDTH-1 -: 10] inside {10'h0FA, 10'h305};
  endproperty
  a_k285: assert property (p_k285) else $error("comma symbol wrong");
  property p_invk; $past(presetn) && $past(tx_k_char) == '0 |-> !invalid_k; endproperty
  a_invk: assert property (p_invk) else $error("invalid K without K");
  property p_txon; $past(presetn) |-> serdes_tx_word != '0; endproperty
  a_txon: assert property (p_txon) else $error("tx lane silent");
endmodule : pcs_word_aligner_props

bind pcs_word_aligner pcs_word_aligner_props #(.SERDES_WORD_WIDTH(SERDES_WORD_WIDTH)) u_props (
  .pclk(pclk), .presetn(presetn), .aligned(aligned),
  .comma_search_request(comma_search_request), .rx_code_err(rx_code_err),
  .rx_disp_err(rx_disp_err), .code_err_n(code_err_n), .tx_data(tx_data),
  .tx_k_char(tx_k_char), .force_disp(force_disp), .serdes_tx_word(serdes_tx_word),
  .invalid_k(invalid_k));

/* File: tb/pcs_serdes_model.sv */
// Transceiver model: loops tx words back to rx, can corrupt them.
// Assumes both lanes share pclk.
`timescale 1ns/100ps
module pcs_serdes_model #(
  parameter int W = 20
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] tx_word,
  input  wire logic         corrupt,
  output logic      [W-1:0] rx_word
);
  // One symbol per slot, bit order kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_word <= '0;
    end else begin
      rx_word <= corrupt ? '0 : tx_word; // All-zero symbols are illegal codes
    end
  end
endmodule : pcs_serdes_model

/* File: tb/tb_top.sv */
// Self-checking bench for the lane core over a loopback transceiver.
// Assumes default top parameters.
`timescale 1ns/100ps
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, corrupt;
  logic        pready, pslverr, irq, invalid_k, aligned, srch, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] tx_data, rx_data;
  logic [1:0]  tx_k_char, rx_k_char, rx_code_err, rx_disp_err, code_err_n;
  logic [19:0] tx_word, rx_word;
  int          n_errors, cmp_count;

  // Shift off, fixed run length
  pcs_word_aligner dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .tx_data(tx_data), .tx_k_char(tx_k_char),
    .force_disp(2'h0), .disp_sel(2'h0), .serdes_tx_word(tx_word), .invalid_k(invalid_k),
    .serdes_rx_word(rx_word), .rx_data(rx_data), .rx_k_char(rx_k_char),
    .rx_code_err(rx_code_err), .rx_disp_err(rx_disp_err), .code_err_n(code_err_n),
    .aligned(aligned), .comma_search_request(srch));
  pcs_serdes_model srd_u (.pclk(pclk), .presetn(presetn), .tx_word(tx_word),
    .corrupt(corrupt), .rx_word(rx_word));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task end_sim;
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : chk

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    chk(n < 20, 1, "apb timeout");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk); // Keeps the next setup off this edge
  endtask : apb

  task wait_al(input logic lvl);
    int n;
    n = 0;
    while (aligned !== lvl && n < 40) begin
      @(posedge pclk);
      n++;
    end
    chk(aligned, lvl, "alignment state");
  endtask : wait_al

  task send(input logic [15:0] d, input logic [1:0] k, input int cyc);
    tx_data <= d;
    tx_k_char <= k;
    repeat (cyc) @(posedge pclk);
  endtask : send

  task t_align;
    send(16'hBCBC, 2'h3, 12);
    wait_al(1'b1);
    chk(srch, 1'b0, "search after lock");
    apb(1'b0, pcs_pkg::REG_CONFIG, 32'h0);
    chk(rd, 32'h0004_0214, "config word");
  endtask : t_align

  task t_irq;
    apb(1'b0, pcs_pkg::REG_IRQ_STAT, 32'h0);
    chk(rd[3:0], 4'h1, "lock event");
    chk(irq, 1'b0, "masked irq");
    apb(1'b1, pcs_pkg::REG_IRQ_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1, "unmasked irq");
    apb(1'b1, pcs_pkg::REG_IRQ_STAT, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0, "cleared irq");
    apb(1'b0, 12'h0FC, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    chk(err, 1'b1, "unmapped error");
  endtask : t_irq

  task t_offset;
    send(16'hBC56, 2'h2, 1);
    send(16'h1234, 2'h0, 1);
    wait_rx(16'hBC56);
    chk({rx_k_char, code_err_n}, 4'hB, "comma word flags");
    @(posedge pclk);
    chk(rx_data, 16'h1234, "byte offset kept");
  endtask : t_offset

  task wait_rx(input logic [15:0] v);
    int n;
    n = 0;
    while (rx_data !== v && n < 40) begin
      @(posedge pclk);
      n++;
    end
    chk(rx_data, v, "rx word");
  endtask : wait_rx

  task t_loss;
    corrupt <= 1'b1;
    repeat (2) @(posedge pclk);
    corrupt <= 1'b0;
    repeat (12) @(posedge pclk);
    chk(aligned, 1'b1, "short burst kept lock");
    corrupt <= 1'b1;
    wait_al(1'b0);
    chk(srch, 1'b1, "search after loss");
    corrupt <= 1'b0;
    send(16'hBCBC, 2'h3, 12);
    wait_al(1'b1);
    apb(1'b1, pcs_pkg::REG_CTRL, 32'h3);
    chk(aligned, 1'b0, "resync drops lock");
    wait_al(1'b1);
  endtask : t_loss

  task t_invk;
    send(16'h0000, 2'h3, 2);
    chk(invalid_k, 1'b1, "invalid K flag");
  endtask : t_invk

  initial begin
    {presetn, psel, penable, pwrite, corrupt} = '0;
    {paddr, pwdata, tx_data, tx_k_char} = '0;
    n_errors = 0;
    cmp_count = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_align;
    t_irq;
    t_offset;
    t_loss;
    t_invk;
    end_sim;
  end

  initial begin
    #(5000 * 4);
    n_errors++;
    end_sim;
  end
endmodule : tb_top
